// [design/mdcr_regs.v]
// Purpose: configuration register bank for a two-channel metering dsp
// Assumes: axi4-lite slave, single clock, synchronous active-low reset
// Notes:   strobe bits self-clear and read as zero
//          soft reset discards the rest of its write, but latch bits 21/22 in it still strobe
//          pulse inputs pass a two-stage synchroniser
//          unaligned addresses answer with slverr
//
// Overview of operation
// - 4-bit per-channel sag/swell clear pulse length
// - bit 4 clears sag/swell, self-clears
// - bit 5 internal reference enable, resets one
// - 3-bit reference tempco select, resets two
// - bit 17 apparent energy from vector power
// - bit 18 vector power from active power
// - bits 19/20 bypass voltage/current high-pass
// - bit 21 inserts coil integrator
// - 4-bit pulse rate scale, reset four
// - 2-bit pulse power type select
// - 2-bit pulse source select
// - 14-bit sag time threshold, reset 0x4E0
// - 2-bit aux pin source or clock select
// - bit 19 tamper enable, 2-bit tolerance
// - bit 20 restores all defaults, self-clears
// - bits 21/22 latch channel measurements, self-clear
// - bit 23 auto-latches at 7.8125 kHz
// - bits 24/25 force pulse pins low
// - bit 26 combined energy is difference
// - phase trims: secondary low, primary high
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "mdcr_defines.vh"

module mdcr_regs (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        clk_en,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         sagswell_clear_a,
	output reg         sagswell_clear_b,
	output reg  [31:0] primary_dsp_control_q,
	output reg  [31:0] secondary_dsp_control_q,
	output reg  [31:0] shared_dsp_control_q,
	output reg  [31:0] phase_compensation_control_q,
	output reg         snapshot_strobe_a,
	output reg         snapshot_strobe_b,
	input  wire        pulse_in_1,
	input  wire        pulse_in_2,
	output reg         pulse_pin_1,
	output reg         pulse_pin_2
);

////////////////////////////////////////////////////////////////////////////////
// write channel capture

reg  [3:0]  awaddr_q;
reg         aw_have_q;
reg  [31:0] wdata_q;
reg  [3:0]  wstrb_q;
reg         w_have_q;
wire        wr_go;
wire        wr_hit;
wire [1:0]  wr_row;
wire        wr_pri;
wire        wr_sec;
wire        wr_shr;
reg  [31:0] bytemask;
integer     i;

assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
assign wr_hit = (awaddr_q <= `MDCR_ADDR_TOP) && (awaddr_q[1:0] == 2'h0);
assign wr_row = awaddr_q[3:2];
// per-row write strobes
assign wr_pri = wr_go && wr_hit && (wr_row == `MDCR_ROW_PRI);
assign wr_sec = wr_go && wr_hit && (wr_row == `MDCR_ROW_SEC);
assign wr_shr = wr_go && wr_hit && (wr_row == `MDCR_ROW_SHR);

always @* begin
	bytemask = 32'h00000000;
	for (i = 0; i < 4; i = i + 1) begin
		bytemask[i*8 +: 8] = {8{wstrb_q[i]}};
	end
end

always @(posedge clk) begin
	if (!rst_b) begin
		aw_have_q     <= 1'b0;
		w_have_q      <= 1'b0;
		awaddr_q      <= 4'h0;
		wdata_q       <= 32'h00000000;
		wstrb_q       <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `MDCR_RESP_OKAY;
	end else if (clk_en) begin
		s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
		s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
		if (wr_go) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `MDCR_RESP_OKAY : `MDCR_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// register file

wire [31:0] wval;
wire        sw_reset;
wire [3:0]  len_a;
wire [3:0]  len_b;

assign wval     = wdata_q & bytemask;
assign sw_reset = wr_shr && wval[`MDCR_SWRST_BIT];

function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [31:0] bm;
	input [31:0] keep;
	begin
		merge = ((old & ~bm) | (nw & bm)) & keep;
	end
endfunction

always @(posedge clk) begin
	if (!rst_b) begin
		primary_dsp_control_q        <= `MDCR_PRI_RST;
		secondary_dsp_control_q      <= `MDCR_SEC_RST;
		shared_dsp_control_q         <= `MDCR_SHR_RST;
		phase_compensation_control_q <= `MDCR_PHC_RST;
	end else if (clk_en) begin
		if (sw_reset) begin
			primary_dsp_control_q        <= `MDCR_PRI_RST;
			secondary_dsp_control_q      <= `MDCR_SEC_RST;
			shared_dsp_control_q         <= `MDCR_SHR_RST;
			phase_compensation_control_q <= `MDCR_PHC_RST;
		end else if (wr_go && wr_hit) begin
			case (wr_row)
				`MDCR_ROW_PRI: primary_dsp_control_q <= merge(primary_dsp_control_q,
					wval, bytemask, `MDCR_CH_MASK);
				`MDCR_ROW_SEC: secondary_dsp_control_q <= merge(secondary_dsp_control_q,
					wval, bytemask, `MDCR_CH_MASK);
				`MDCR_ROW_SHR: shared_dsp_control_q <= merge(shared_dsp_control_q,
					wval, bytemask, `MDCR_SHR_MASK);
				default: phase_compensation_control_q <= merge(
					phase_compensation_control_q, wval, bytemask, `MDCR_PHC_MASK);
			endcase
		end
	end
end

// length taken from the write that sets the clear bit
assign len_a = wval[`MDCR_CLR_LEN_LSB +: 4];
assign len_b = wval[`MDCR_CLR_LEN_LSB +: 4];

////////////////////////////////////////////////////////////////////////////////
// sag/swell clear pulses and measurement latch strobes

reg  [4:0]  clr_cnt_a_q;
reg  [4:0]  clr_cnt_b_q;
reg  [11:0] auto_cnt_q;
wire        clr_req_a;
wire        clr_req_b;
wire        auto_tick;

assign clr_req_a = wr_pri && wval[`MDCR_CLR_BIT];
assign clr_req_b = wr_sec && wval[`MDCR_CLR_BIT];
assign auto_tick = shared_dsp_control_q[`MDCR_AUTO_BIT]
	&& (auto_cnt_q == `MDCR_AUTO_LAST);

always @(posedge clk) begin
	if (!rst_b) begin
		clr_cnt_a_q       <= 5'h00;
		clr_cnt_b_q       <= 5'h00;
		sagswell_clear_a  <= 1'b0;
		sagswell_clear_b  <= 1'b0;
		auto_cnt_q        <= 12'h000;
		snapshot_strobe_a <= 1'b0;
		snapshot_strobe_b <= 1'b0;
	end else if (clk_en) begin
		// pulse lasts len+1 cycles
		if (clr_req_a) begin
			clr_cnt_a_q      <= {1'b0, len_a} + 5'h01;
			sagswell_clear_a <= 1'b1;
		end else if (clr_cnt_a_q > 5'h01) begin
			clr_cnt_a_q <= clr_cnt_a_q - 5'h01;
		end else begin
			clr_cnt_a_q      <= 5'h00;
			sagswell_clear_a <= 1'b0;
		end
		if (clr_req_b) begin
			clr_cnt_b_q      <= {1'b0, len_b} + 5'h01;
			sagswell_clear_b <= 1'b1;
		end else if (clr_cnt_b_q > 5'h01) begin
			clr_cnt_b_q <= clr_cnt_b_q - 5'h01;
		end else begin
			clr_cnt_b_q      <= 5'h00;
			sagswell_clear_b <= 1'b0;
		end
		if (!shared_dsp_control_q[`MDCR_AUTO_BIT] || auto_tick) begin
			auto_cnt_q <= 12'h000;
		end else begin
			auto_cnt_q <= auto_cnt_q + 12'h001;
		end
		snapshot_strobe_a <= auto_tick || (wr_shr && wval[`MDCR_LATCH_A_BIT]);
		snapshot_strobe_b <= auto_tick || (wr_shr && wval[`MDCR_LATCH_B_BIT]);
	end
end

////////////////////////////////////////////////////////////////////////////////
// pulse pins

wire pin1_s;
wire pin2_s;

mdcr_sync2 #(
	.WIDTH(1)
) mdcr_sync2_pin1_i (
	.clk      (clk),
	.rst_b    (rst_b),
	.clk_en   (clk_en),
	.async_in (pulse_in_1),
	.sync_out (pin1_s)
);

mdcr_sync2 #(
	.WIDTH(1)
) mdcr_sync2_pin2_i (
	.clk      (clk),
	.rst_b    (rst_b),
	.clk_en   (clk_en),
	.async_in (pulse_in_2),
	.sync_out (pin2_s)
);

always @(posedge clk) begin
	if (!rst_b) begin
		pulse_pin_1 <= 1'b0;
		pulse_pin_2 <= 1'b0;
	end else if (clk_en) begin
		pulse_pin_1 <= pin1_s && !shared_dsp_control_q[`MDCR_LEDOFF1_BIT];
		pulse_pin_2 <= pin2_s && !shared_dsp_control_q[`MDCR_LEDOFF2_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// read channel

wire        rd_hit;
wire [1:0]  rd_row;

// unaligned reads answer slverr with zero data
assign rd_hit = (s_axi_araddr[1:0] == 2'h0);
assign rd_row = s_axi_araddr[3:2];

always @(posedge clk) begin
	if (!rst_b) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h00000000;
		s_axi_rresp   <= `MDCR_RESP_OKAY;
	end else if (clk_en) begin
		s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `MDCR_RESP_OKAY;
			if (!rd_hit) begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `MDCR_RESP_SLVERR;
			end else begin
				case (rd_row)
					`MDCR_ROW_PRI: s_axi_rdata <= primary_dsp_control_q;
					`MDCR_ROW_SEC: s_axi_rdata <= secondary_dsp_control_q;
					`MDCR_ROW_SHR: s_axi_rdata <= shared_dsp_control_q;
					default:       s_axi_rdata <= phase_compensation_control_q;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser for inputs from outside the clock domain

module mdcr_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             rst_b,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_q;

always @(posedge clk) begin
	if (!rst_b) begin
		meta_q   <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else if (clk_en) begin
		meta_q   <= async_in;
		sync_out <= meta_q;
	end
end

endmodule

// [design/mdcr_defines.vh]
// Purpose: constants for the metering dsp configuration register bank
// Assumes: 32-bit axi4-lite register bus, 20 MHz core clock
// Notes:   byte addresses are row index times four
`ifndef MDCR_DEFINES_VH
`define MDCR_DEFINES_VH

`define MDCR_ROW_PRI          2'h0
`define MDCR_ROW_SEC          2'h1
`define MDCR_ROW_SHR          2'h2
`define MDCR_ROW_PHC          2'h3
`define MDCR_ADDR_W           4
`define MDCR_ADDR_TOP         4'hC

`define MDCR_PRI_RST          32'h040000A0
`define MDCR_SEC_RST          32'h240000A0
`define MDCR_SHR_RST          32'h000004E0
`define MDCR_PHC_RST          32'h00000000

`define MDCR_CH_MASK          32'hFF3E01EF
`define MDCR_SHR_MASK         32'h0F8FFFFF
`define MDCR_PHC_MASK         32'h00FFFFFF

`define MDCR_CLR_LEN_LSB      0
`define MDCR_CLR_BIT          4
`define MDCR_VREF_BIT         5
`define MDCR_TC_LSB           6
`define MDCR_AEM_BIT          17
`define MDCR_APM_BIT          18
`define MDCR_HPFV_BIT         19
`define MDCR_HPFC_BIT         20
`define MDCR_ROC_BIT          21
`define MDCR_LPW_LSB          24
`define MDCR_LPS_LSB          28
`define MDCR_LCS_LSB          30

`define MDCR_TIME_LSB         0
`define MDCR_ZSEL_LSB         14
`define MDCR_ZEN_BIT          16
`define MDCR_TOL_LSB          17
`define MDCR_TMP_BIT          19
`define MDCR_SWRST_BIT        20
`define MDCR_LATCH_A_BIT      21
`define MDCR_LATCH_B_BIT      22
`define MDCR_AUTO_BIT         23
`define MDCR_LEDOFF1_BIT      24
`define MDCR_LEDOFF2_BIT      25
`define MDCR_CUM_BIT          26
`define MDCR_FREQ_BIT         27

`define MDCR_CLK_HZ           20000000
`define MDCR_AUTO_DIV         2560
`define MDCR_AUTO_LAST        12'h9FF
`define MDCR_AUTO_W           12

`define MDCR_RESP_OKAY        2'h0
`define MDCR_RESP_SLVERR      2'h2

`endif

// [bench/mdcr_regs_properties.sv]
// Purpose: checker for the dsp configuration register bank
// Assumes: clk_en dropped only while the bank is idle
// Notes:   masks follow the field layout of each row
`timescale 1ns/10ps
module mdcr_regs_properties (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        sagswell_clear_a,
	input wire logic        sagswell_clear_b,
	input wire logic [31:0] primary_dsp_control_q,
	input wire logic [31:0] secondary_dsp_control_q,
	input wire logic [31:0] shared_dsp_control_q,
	input wire logic [31:0] phase_compensation_control_q,
	input wire logic        snapshot_strobe_a,
	input wire logic        snapshot_strobe_b,
	input wire logic        pulse_pin_1,
	input wire logic        pulse_pin_2
);
	logic [4:0]  clr_a_q;
	logic [4:0]  clr_b_q;
	logic [11:0] gap_q;
	wire         auto_on = shared_dsp_control_q[23];
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		clr_a_q <= (rst_b && sagswell_clear_a) ? clr_a_q + 5'h1 : 5'h0;
		clr_b_q <= (rst_b && sagswell_clear_b) ? clr_b_q + 5'h1 : 5'h0;
		gap_q   <= (!rst_b || snapshot_strobe_a || !auto_on) ? 12'h0 : gap_q + 12'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_reserved_zero:
	assert property ((primary_dsp_control_q & 32'h00C1FE10) == 32'h0
		&& (secondary_dsp_control_q & 32'h00C1FE10) == 32'h0
		&& (shared_dsp_control_q & 32'hF0700000) == 32'h0
		&& (phase_compensation_control_q & 32'hFF000000) == 32'h0) else $error("reserved set");
	a_reset_values:
	assert property ($rose(rst_b) |-> primary_dsp_control_q == 32'h040000A0
		&& secondary_dsp_control_q == 32'h240000A0 && shared_dsp_control_q == 32'h000004E0
		&& phase_compensation_control_q == 32'h0) else $error("bad reset value");
	a_clear_len_a:
	assert property ($fell(sagswell_clear_a) |-> clr_a_q == {1'b0, primary_dsp_control_q[3:0]} + 5'h1)
		else $error("clear a length");
	a_clear_len_b:
	assert property ($fell(sagswell_clear_b) |-> clr_b_q == {1'b0, secondary_dsp_control_q[3:0]} + 5'h1)
		else $error("clear b length");
	a_snap_single:
	assert property (snapshot_strobe_a || snapshot_strobe_b |=> !snapshot_strobe_a && !snapshot_strobe_b)
		else $error("strobe too long");
	a_pin_off_one:
	assert property (shared_dsp_control_q[24] |=> !pulse_pin_1) else $error("pin 1 not low");
	a_pin_off_two:
	assert property (shared_dsp_control_q[25] |=> !pulse_pin_2) else $error("pin 2 not low");
	a_auto_period:
	assert property (auto_on |-> gap_q <= 12'hA00) else $error("auto latch missing");
endmodule
bind mdcr_regs mdcr_regs_properties mdcr_regs_properties_i (.clk, .rst_b, .sagswell_clear_a,
	.sagswell_clear_b, .primary_dsp_control_q, .secondary_dsp_control_q, .shared_dsp_control_q,
	.phase_compensation_control_q, .snapshot_strobe_a, .snapshot_strobe_b, .pulse_pin_1,
	.pulse_pin_2);

// [bench/mdcr_regs_tb_top.sv]
// Purpose: register tests for the dsp configuration bank
// Assumes: auto latch period of 2560 cycles
// Notes:   expectations built from field layout
`timescale 1ns/10ps
module mdcr_regs_tb_top;
	reg         clk = 1'b0, rst_b = 1'b0, pin1 = 1'b1, pin2 = 1'b1, clk_en = 1'b1;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg  [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	reg  [31:0] wdata = 32'h0;
	reg  [1:0]  v;
	wire        awready, wready, bvalid, arready, rvalid, clr_a, clr_b, snap_a, snap_b, led1, led2;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	integer     num_errors = 0, checked = 0, cyc = 0, n_a = 0, n_b = 0, n_c = 0, n_d = 0, k;
	////////////////////////////////////////////////////////////////
	mdcr_regs mdcr_regs_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sagswell_clear_a(clr_a), .sagswell_clear_b(clr_b),
		.primary_dsp_control_q(), .secondary_dsp_control_q(), .shared_dsp_control_q(),
		.phase_compensation_control_q(), .snapshot_strobe_a(snap_a), .snapshot_strobe_b(snap_b),
		.pulse_in_1(pin1), .pulse_in_2(pin2), .pulse_pin_1(led1), .pulse_pin_2(led2));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		n_a = n_a + clr_a;
		n_b = n_b + clr_b;
		n_c = n_c + snap_a;
		n_d = n_d + snap_b;
		if (cyc == 7000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t got %h exp %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		begin
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			@(posedge clk);
			while (awvalid || wvalid || !bvalid) begin
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				@(posedge clk);
			end
			check({30'h0, bresp}, {30'h0, er});
			bready <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [3:0] a, input [31:0] e, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge clk);
			while (arvalid || !rvalid) begin
				if (arready) arvalid <= 1'b0;
				@(posedge clk);
			end
			check(rdata, e);
			check({30'h0, rresp}, {30'h0, er});
			rready <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wrd(input [3:0] a, input [31:0] d, input [31:0] e);
		begin
			wr(a, d, 4'hF, 2'h0);
			rd(a, e, 2'h0);
		end
	endtask
	task wrap_up;
		begin
			$display("mismatches %0d checks %0d", num_errors, checked);
			if (num_errors == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(4'h0, 32'h040000A0, 2'h0);
		rd(4'h4, 32'h240000A0, 2'h0);
		rd(4'h8, 32'h000004E0, 2'h0);
		rd(4'hC, 32'h0, 2'h0);
		$display("reset values done");
		wrd(4'h0, 32'hFFFFFFEF, 32'hFF3E01EF);
		wrd(4'h4, 32'hFFFFFFEF, 32'hFF3E01EF);
		wr(4'hC, 32'hFFFFFFFF, 4'h1, 2'h0);
		rd(4'hC, 32'h000000FF, 2'h0);
		wrd(4'hC, 32'hFFFFFFFF, 32'h00FFFFFF);
		wrd(4'h8, 32'hFF0FFFFF, 32'h0F0FFFFF);
		check({30'h0, led1, led2}, 32'h0);
		wrd(4'h8, 32'h0, 32'h0);
		check({30'h0, led1, led2}, 32'h3);
		$display("field layout done");
		for (k = 0; k < 4; k = k + 1) begin
			v = k;
			wrd(4'h0, {v, v, 2'h0, v, 24'h0}, {v, v, 2'h0, v, 24'h0});
			wrd(4'h8, {13'h0, v, 1'b1, v, 14'h0}, {13'h0, v, 1'b1, v, 14'h0});
		end
		$display("encodings done");
		n_a = 0;
		n_b = 0;
		wrd(4'h0, 32'h00000013, 32'h00000003);
		wrd(4'h4, 32'h0000001F, 32'h0000000F);
		repeat (20) @(posedge clk);
		check(n_a, 4);
		check(n_b, 16);
		$display("clear pulse done");
		n_c = 0;
		n_d = 0;
		wrd(4'h8, 32'h00200000, 32'h0);
		check(n_c, 1);
		wrd(4'h8, 32'h00400000, 32'h0);
		check(n_d, 1);
		check(n_c, 1);
		wrd(4'h8, 32'h00800000, 32'h00800000);
		n_c = 0;
		repeat (5120) @(posedge clk);
		check(n_c, 2);
		check(n_d, 3);
		wr(4'h8, 32'h0, 4'hF, 2'h0);
		clk_en <= 1'b0;
		pin1 <= 1'b0;
		repeat (6) @(posedge clk);
		check({31'h0, led1}, 32'h1);
		clk_en <= 1'b1;
		repeat (6) @(posedge clk);
		check({31'h0, led1}, 32'h0);
		pin1 <= 1'b1;
		$display("latch done");
		wr(4'h0, 32'h00012345, 4'hF, 2'h0);
		wr(4'h8, 32'h00100ABC, 4'hF, 2'h0);
		rd(4'h0, 32'h040000A0, 2'h0);
		rd(4'h8, 32'h000004E0, 2'h0);
		wr(4'h2, 32'hFFFFFFFF, 4'hF, 2'h2);
		rd(4'h2, 32'h0, 2'h2);
		rd(4'h0, 32'h040000A0, 2'h0);
		$display("soft reset and unmapped done");
		wrap_up;
	end
endmodule
